// ---- src/serial_port.v ----
// serial port: mode 0 shift register and mode 1 ten-bit frames
// assumes ref_clk is the oscillator and control bits come from
// software registers clocked on ref_clk; pins are asynchronous
`timescale 1ns/10ps
`default_nettype none

`include "serial_port_defines.vh"

module serial_port (
  input  wire       ref_clk,
  input  wire       rst,
  input  wire       port_two_sel,
  input  wire       rx_baud_from_timer2_sel,
  input  wire       tx_baud_from_timer2_sel,
  input  wire       port2_rx_baud_sel,
  input  wire       port2_tx_baud_sel,
  input  wire       timer1_tick16,
  input  wire       timer2_run,
  input  wire       timer2_counter_select,
  input  wire       timer2_ext_enable,
  input  wire       timer2_ext_pin,
  input  wire       timer2_count_pin,
  input  wire       timer2_wr_high,
  input  wire       timer2_wr_low,
  input  wire       timer2_wr_rld_high,
  input  wire       timer2_wr_rld_low,
  input  wire [7:0] timer2_wr_data,
  input  wire       timer2_ovf_clr,
  input  wire       timer2_ext_clr,
  input  wire [1:0] serial_mode,
  input  wire       rx_enable,
  input  wire       multiproc_filter_bit,
  input  wire       buf_wr,
  input  wire [7:0] buf_wr_data,
  input  wire       tx_flag_clr,
  input  wire       rx_flag_clr,
  input  wire       rxd_in,
  output reg        rxd_out_r,
  output reg        rxd_oe_r,
  output reg        txd_out_r,
  output reg  [7:0] serial_buffer_r,
  output reg        rx_ninth_bit_r,
  output reg        tx_done_flag_r,
  output reg        rx_done_flag_r,
  output wire [7:0] timer2_high_byte,
  output wire [7:0] timer2_low_byte,
  output wire [7:0] timer2_reload_high,
  output wire [7:0] timer2_reload_low,
  output wire       timer2_overflow_flag,
  output wire       timer2_ext_flag
);

  // ----------------------------------------------------------------
  // state encodings
  // ----------------------------------------------------------------
  localparam [3:0] TX_IDLE = 4'h1;
  localparam [3:0] TX_ARM  = 4'h2;
  localparam [3:0] TX_GO   = 4'h4;
  localparam [3:0] TX_SEND = 4'h8;
  localparam [3:0] RX_IDLE = 4'h1;
  localparam [3:0] RX_LOAD = 4'h2;
  localparam [3:0] RX_RECV = 4'h4;
  localparam [3:0] RX_DONE = 4'h8;

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  reg  [3:0] ph_r;
  reg  [3:0] tx_st_r;
  reg  [3:0] rx_st_r;
  reg  [8:0] tsr_r;
  reg  [8:0] rsr_r;
  reg  [3:0] tdiv_r;
  reg  [3:0] rdiv_r;
  reg        tx_data_r;
  reg        tx_last_r;
  reg        rx_first_r;
  reg        smp_a_r;
  reg        smp_b_r;
  reg        rx_prev_r;
  reg        ext_prev_r;
  reg        cnt_prev_r;
  reg        tx_set;
  reg        rx_set;
  wire [2:0] pins_s;
  wire       rxd_s;
  wire       ext_s;
  wire       cnt_s;
  wire       mode0;
  wire       mode1;
  wire       ph_s1p1;
  wire       ph_s6p2;
  wire       state_tick;
  wire       mc_tick;
  wire       sclk;
  wire       rx_t2;
  wire       tx_t2;
  wire       t2_baud;
  wire       t2_ovf;
  wire       rx_tick;
  wire       tx_tick;
  wire       tx_roll;
  wire       vote;
  wire [8:0] rsr_sh0;
  wire [8:0] rsr_sh1;
  wire       rx_edge;
  wire       rx_keep;

  // ----------------------------------------------------------------
  // bit order helper
  // ----------------------------------------------------------------

  // data shifts in lsb first at the right end, so flip it for the buffer
  function [7:0] flip8;
    input [7:0] v;
    integer i;
    begin
      for (i = 0; i < 8; i = i + 1) begin
        flip8[i] = v[7 - i];
      end
    end
  endfunction

  // ----------------------------------------------------------------
  // pins, machine cycle timing
  // ----------------------------------------------------------------

  // receive, timer 2 external and count pins
  pin_sync #(
    .W (3)
  ) u_sync (
    .ref_clk    (ref_clk),
    .rst        (rst),
    .pin_in     ({timer2_count_pin, timer2_ext_pin, rxd_in}),
    .pin_sync_r (pins_s)
  );

  assign rxd_s = pins_s[0];
  assign ext_s = pins_s[1];
  assign cnt_s = pins_s[2];

  // twelve oscillator phases to the machine cycle
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ph_r <= `PH_S1P1;
    end else if (ph_r == `PH_LAST) begin
      ph_r <= `PH_S1P1;
    end else begin
      ph_r <= ph_r + 4'h1;
    end
  end

  assign ph_s1p1    = (ph_r == `PH_S1P1);
  assign ph_s6p2    = (ph_r == `PH_S6P2);
  assign state_tick = ph_r[0];             // every P2
  assign mc_tick    = ph_s6p2;
  assign mode0      = (serial_mode == `MODE_SHIFT);
  assign mode1      = (serial_mode == `MODE_UART8);

  // shift clock low from S3P1 through S5P2
  assign sclk = ~((ph_r >= `PH_S3P1) &&
                  (ph_r <= `PH_S5P2));

  // ----------------------------------------------------------------
  // baud source selection and timer 2
  // ----------------------------------------------------------------

  // each port takes its select bits from its own register
  assign rx_t2 = port_two_sel ? port2_rx_baud_sel
                              : rx_baud_from_timer2_sel;
  assign tx_t2 = port_two_sel ? port2_tx_baud_sel
                              : tx_baud_from_timer2_sel;
  assign t2_baud = rx_baud_from_timer2_sel | tx_baud_from_timer2_sel |
                   port2_rx_baud_sel | port2_tx_baud_sel;

  // timer 2 overflow pulses or timer1_tick16, per select bit, are the 16x tick of each direction
  assign rx_tick = rx_t2 ? t2_ovf : timer1_tick16;
  assign tx_tick = tx_t2 ? t2_ovf : timer1_tick16;

  // falling edges of the timer 2 pins
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ext_prev_r <= 1'b1;
      cnt_prev_r <= 1'b1;
    end else begin
      ext_prev_r <= ext_s;
      cnt_prev_r <= cnt_s;
    end
  end

  timer2_baud u_t2 (
    .ref_clk        (ref_clk),
    .rst            (rst),
    .state_tick     (state_tick),
    .mc_tick        (mc_tick),
    .count_edge     (cnt_prev_r & ~cnt_s),
    .ext_fall       (ext_prev_r & ~ext_s),
    .baud_mode      (t2_baud),
    .run            (timer2_run),
    .counter_select (timer2_counter_select),
    .ext_enable     (timer2_ext_enable),
    .wr_high        (timer2_wr_high),
    .wr_low         (timer2_wr_low),
    .wr_rld_high    (timer2_wr_rld_high),
    .wr_rld_low     (timer2_wr_rld_low),
    .wr_data        (timer2_wr_data),
    .clr_ovf_flag   (timer2_ovf_clr),
    .clr_ext_flag   (timer2_ext_clr),
    .timer_high_r   (timer2_high_byte),
    .timer_low_r    (timer2_low_byte),
    .reload_high_r  (timer2_reload_high),
    .reload_low_r   (timer2_reload_low),
    .ovf_pulse_r    (t2_ovf),
    .ovf_flag_r     (timer2_overflow_flag),
    .ext_flag_r     (timer2_ext_flag)
  );

  // ----------------------------------------------------------------
  // transmit
  // ----------------------------------------------------------------

  // divide-by-16 of the transmit tick
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      tdiv_r <= 4'h0;
    end else if (tx_tick) begin
      tdiv_r <= tdiv_r + 4'h1;
    end
  end

  assign tx_roll = tx_tick & (tdiv_r == `DIV_LAST);

  // transmit sequencer for both modes
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      tx_st_r   <= TX_IDLE;
      tsr_r     <= 9'h000;
      tx_data_r <= 1'b0;
      tx_last_r <= 1'b0;
      tx_set    <= 1'b0;
    end else begin
      tx_set <= 1'b0;
      if (buf_wr) begin
        tsr_r     <= {1'b1, buf_wr_data};
        tx_st_r   <= TX_ARM;
        tx_data_r <= 1'b0;
        tx_last_r <= 1'b0;
      end else begin
        case (tx_st_r)
          TX_IDLE: begin
            tx_data_r <= 1'b0;
          end
          TX_ARM: begin
            // mode 0 waits for S6P2, mode 1 a rollover
            if ((mode0 & ph_s6p2) | (mode1 & tx_roll)) begin
              tx_st_r <= TX_GO;
            end
          end
          TX_GO: begin
            if (ph_s1p1) begin
              tx_st_r <= TX_SEND;
            end
          end
          TX_SEND: begin
            if (mode0) begin
              if (ph_s1p1 & tx_last_r) begin
                tx_st_r <= TX_IDLE;
                tx_set  <= 1'b1;
              end else if (ph_s6p2 & ~tx_last_r) begin
                tsr_r <= {1'b0, tsr_r[8:1]};
                if (tsr_r[8:1] == `TX_MARK_LEFT) begin
                  tx_last_r <= 1'b1;
                end
              end
            end else if (tx_roll) begin
              if (~tx_data_r) begin
                tx_data_r <= 1'b1;
              end else begin
                tsr_r <= {1'b0, tsr_r[8:1]};
                if (tsr_r[8:1] == `TX_MARK_LEFT) begin
                  tx_st_r   <= TX_IDLE;
                  tx_data_r <= 1'b0;
                  tx_set    <= 1'b1;
                end
              end
            end
          end
          default: begin
            tx_st_r <= TX_IDLE;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // receive
  // ----------------------------------------------------------------

  assign vote    = (smp_a_r & smp_b_r) | (smp_a_r & rxd_s) |
                   (smp_b_r & rxd_s);
  assign rsr_sh0 = {rsr_r[7:0], smp_a_r};
  assign rsr_sh1 = {rsr_r[7:0], vote};
  assign rx_edge = rx_tick & rx_prev_r & ~rxd_s;
  assign rx_keep = ~rx_done_flag_r &
                   (~multiproc_filter_bit | vote);

  // receive sequencer for both modes
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rx_st_r         <= RX_IDLE;
      rsr_r           <= 9'h1ff;
      rdiv_r          <= 4'h0;
      rx_first_r      <= 1'b0;
      smp_a_r         <= 1'b1;
      smp_b_r         <= 1'b1;
      rx_prev_r       <= 1'b1;
      rx_set          <= 1'b0;
      serial_buffer_r <= 8'h00;
      rx_ninth_bit_r  <= 1'b0;
    end else begin
      rx_set <= 1'b0;
      if (rx_tick) begin
        rx_prev_r <= rxd_s; // pin looked at 16 times a bit
      end
      case (rx_st_r)
        RX_IDLE: begin
          if (mode0 & rx_enable & ~rx_done_flag_r & ph_s1p1) begin
            rx_st_r <= RX_LOAD;
          end else if (mode1 & rx_enable & rx_edge) begin
            rx_st_r    <= RX_RECV;
            rdiv_r     <= 4'h0;
            rsr_r      <= `RX1_LOAD;
            rx_first_r <= 1'b1;
          end
        end
        RX_LOAD: begin
          if (ph_s6p2) begin
            rsr_r   <= `RX0_LOAD;
            rx_st_r <= RX_RECV;
          end
        end
        RX_RECV: begin
          if (mode0) begin
            if (ph_r == `PH_S5P2) begin
              smp_a_r <= rxd_s;
            end
            if (ph_s6p2) begin
              rsr_r <= rsr_sh0;
              if (~rsr_sh0[8]) begin
                serial_buffer_r <= flip8(rsr_sh0[7:0]);
                rx_st_r         <= RX_DONE;
              end
            end
          end else if (rx_tick) begin
            rdiv_r <= rdiv_r + 4'h1;
            if (rdiv_r == `SMP_A) begin
              smp_a_r <= rxd_s;
            end
            if (rdiv_r == `SMP_B) begin
              smp_b_r <= rxd_s;
            end
            if (rdiv_r == `SMP_C) begin
              rx_first_r <= 1'b0;
              if (rx_first_r & vote) begin
                rx_st_r <= RX_IDLE;
              end else begin
                rsr_r <= rsr_sh1;
                if (~rsr_r[8]) begin
                  rx_st_r <= RX_IDLE;
                  if (rx_keep) begin
                    serial_buffer_r <= flip8(rsr_sh1[8:1]);
                    rx_ninth_bit_r  <= vote;
                    rx_set          <= 1'b1;
                  end
                end
              end
            end
          end
        end
        RX_DONE: begin
          if (ph_s1p1) begin
            rx_st_r <= RX_IDLE;
            rx_set  <= 1'b1;
          end
        end
        default: begin
          rx_st_r <= RX_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // flags and pins
  // ----------------------------------------------------------------

  // hardware sets, software clears, set wins
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      tx_done_flag_r <= 1'b0;
      rx_done_flag_r <= 1'b0;
    end else begin
      tx_done_flag_r <= tx_set | (tx_done_flag_r & ~tx_flag_clr);
      rx_done_flag_r <= rx_set | (rx_done_flag_r & ~rx_flag_clr);
    end
  end

  // mode 0 data on rxd and clock on txd, mode 1 frame on txd
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rxd_out_r <= 1'b1;
      rxd_oe_r  <= 1'b0;
      txd_out_r <= 1'b1;
    end else begin
      rxd_out_r <= tsr_r[0];
      rxd_oe_r  <= mode0 & (tx_st_r == TX_SEND);
      if (mode0) begin
        txd_out_r <= ((tx_st_r == TX_SEND) | (rx_st_r == RX_RECV)) ?
                     sclk : 1'b1;
      end else if (tx_st_r == TX_SEND) begin
        txd_out_r <= tx_data_r & tsr_r[0];
      end else begin
        txd_out_r <= 1'b1;
      end
    end
  end

endmodule

`default_nettype wire

// ---- src/serial_port_defines.vh ----
// constants for the serial port with shift and 10-bit frame modes
// assumes ref_clk is the oscillator: 12 clocks to one machine cycle
`ifndef SERIAL_PORT_DEFINES_VH
`define SERIAL_PORT_DEFINES_VH

// ----------------------------------------------------------------
// machine cycle slots: index = 2 * (state - 1) + (phase - 1)
// ----------------------------------------------------------------
`define PH_LAST      4'hb
`define PH_S1P1      4'h0
`define PH_S3P1      4'h4
`define PH_S5P2      4'h9
`define PH_S6P2      4'hb

// ----------------------------------------------------------------
// modes, patterns and counter states
// ----------------------------------------------------------------
`define MODE_SHIFT   2'h0
`define MODE_UART8   2'h1
`define RX0_LOAD     9'h1fe
`define RX1_LOAD     9'h1ff
`define TX_MARK_LEFT 8'h01
`define DIV_LAST     4'hf
`define SMP_A        4'h7
`define SMP_B        4'h8
`define SMP_C        4'h9
`define T2_TOP       16'hffff

`endif

// ---- src/pin_sync.v ----
// two-flop synchroniser for a group of pin inputs
// assumes the pins are asynchronous to ref_clk
`timescale 1ns/10ps
`default_nettype none

module pin_sync #(
  parameter W = 1
) (
  input  wire         ref_clk,
  input  wire         rst,
  input  wire [W-1:0] pin_in,
  output reg  [W-1:0] pin_sync_r
);

  reg [W-1:0] meta_r;

  // first stage is read only by the second
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      meta_r     <= {W{1'b1}};
      pin_sync_r <= {W{1'b1}};
    end else begin
      meta_r     <= pin_in;
      pin_sync_r <= meta_r;
    end
  end

endmodule

`default_nettype wire

// ---- src/timer2_baud.v ----
// timer 2 with auto-reload and baud generator mode
// assumes state_tick, mc_tick and pin edges come from ref_clk logic
`timescale 1ns/10ps
`default_nettype none

`include "serial_port_defines.vh"

module timer2_baud (
  input  wire       ref_clk,
  input  wire       rst,
  input  wire       state_tick,
  input  wire       mc_tick,
  input  wire       count_edge,
  input  wire       ext_fall,
  input  wire       baud_mode,
  input  wire       run,
  input  wire       counter_select,
  input  wire       ext_enable,
  input  wire       wr_high,
  input  wire       wr_low,
  input  wire       wr_rld_high,
  input  wire       wr_rld_low,
  input  wire [7:0] wr_data,
  input  wire       clr_ovf_flag,
  input  wire       clr_ext_flag,
  output reg  [7:0] timer_high_r,
  output reg  [7:0] timer_low_r,
  output reg  [7:0] reload_high_r,
  output reg  [7:0] reload_low_r,
  output reg        ovf_pulse_r,
  output reg        ovf_flag_r,
  output reg        ext_flag_r
);

  wire        cnt_src;
  wire        inc;
  wire        ovf;
  wire        ext_ev;
  wire        ext_rld;
  wire [15:0] cnt_inc;

  // counter select counts count pin falls, else baud mode counts state times, else machine cycles
  assign cnt_src = counter_select ? count_edge :
                   (baud_mode ? state_tick : mc_tick);
  assign inc     = run & cnt_src;
  assign cnt_inc = {timer_high_r, timer_low_r} + 16'h0001;
  assign ovf     = inc & ({timer_high_r, timer_low_r} == `T2_TOP);
  assign ext_ev  = ext_enable & ext_fall;
  assign ext_rld = ext_ev & ~baud_mode;

  // counter, reload on overflow, software writes win
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      timer_high_r  <= 8'h00;
      timer_low_r   <= 8'h00;
      reload_high_r <= 8'h00;
      reload_low_r  <= 8'h00;
      ovf_pulse_r   <= 1'b0;
    end else begin
      ovf_pulse_r <= ovf;
      if (ovf | ext_rld) begin
        timer_high_r <= reload_high_r;
        timer_low_r  <= reload_low_r;
      end else if (inc) begin
        timer_high_r <= cnt_inc[15:8];
        timer_low_r  <= cnt_inc[7:0];
      end
      if (wr_high) timer_high_r <= wr_data;
      if (wr_low) timer_low_r <= wr_data;
      if (wr_rld_high) reload_high_r <= wr_data;
      if (wr_rld_low) reload_low_r <= wr_data;
    end
  end

  // sticky flags, a set wins over a clear
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ovf_flag_r <= 1'b0;
      ext_flag_r <= 1'b0;
    end else begin
      ovf_flag_r <= (ovf & ~baud_mode) |
                    (ovf_flag_r & ~clr_ovf_flag);
      ext_flag_r <= ext_ev | (ext_flag_r & ~clr_ext_flag);
    end
  end

endmodule

`default_nettype wire

// ---- verif/serial_port_props.sv ----
// assertions on the serial port top-level pins
// assumes it is bound into serial_port, one clock ref_clk
`timescale 1ns/10ps
`default_nettype none

module serial_port_props (
  input wire logic       ref_clk,
  input wire logic       rst,
  input wire logic       rx_baud_from_timer2_sel,
  input wire logic       tx_baud_from_timer2_sel,
  input wire logic       port2_rx_baud_sel,
  input wire logic       port2_tx_baud_sel,
  input wire logic       timer2_run,
  input wire logic       timer2_ext_enable,
  input wire logic       timer2_ext_pin,
  input wire logic [1:0] serial_mode,
  input wire logic       multiproc_filter_bit,
  input wire logic       tx_flag_clr,
  input wire logic       rx_flag_clr,
  input wire logic       txd_out_r,
  input wire logic [7:0] serial_buffer_r,
  input wire logic       rx_ninth_bit_r,
  input wire logic       tx_done_flag_r,
  input wire logic       rx_done_flag_r,
  input wire logic [7:0] timer2_high_byte,
  input wire logic [7:0] timer2_low_byte,
  input wire logic       timer2_overflow_flag,
  input wire logic       timer2_ext_flag
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  wire baud_sel;
  // any select bit puts timer 2 in baud mode
  assign baud_sel = rx_baud_from_timer2_sel | tx_baud_from_timer2_sel |
                    port2_rx_baud_sel | port2_tx_baud_sel;

  property p_no_ovf;
    baud_sel |-> !$rose(timer2_overflow_flag);
  endproperty
  a_no_ovf: assert property (p_no_ovf)
    else $error("overflow flag set in baud mode");
  property p_ext_flag;
    baud_sel && timer2_ext_enable && $fell(timer2_ext_pin)
      |-> ##[1:6] timer2_ext_flag;
  endproperty
  a_ext_flag: assert property (p_ext_flag)
    else $error("ext flag not set by pin fall");
  property p_ext_no_reload;
    baud_sel && !timer2_run && $rose(timer2_ext_flag)
      |-> $stable(timer2_high_byte) && $stable(timer2_low_byte);
  endproperty
  a_ext_no_reload: assert property (p_ext_no_reload)
    else $error("pin fall reloaded the timer");
  property p_m0_clk_low;
    serial_mode == 2'h0 && $fell(txd_out_r) |-> !txd_out_r[*6] ##1 txd_out_r;
  endproperty
  a_m0_clk_low: assert property (p_m0_clk_low)
    else $error("shift clock low time wrong");
  property p_tx_hold;
    tx_done_flag_r && !tx_flag_clr |=> tx_done_flag_r;
  endproperty
  a_tx_hold: assert property (p_tx_hold)
    else $error("tx flag dropped without clear");
  property p_rx_hold;
    rx_done_flag_r && !rx_flag_clr |=> rx_done_flag_r;
  endproperty
  a_rx_hold: assert property (p_rx_hold)
    else $error("rx flag dropped without clear");
  property p_buf_kept;
    rx_done_flag_r |=> $stable(serial_buffer_r);
  endproperty
  a_buf_kept: assert property (p_buf_kept)
    else $error("buffer loaded while rx flag set");
  property p_ninth;
    serial_mode == 2'h1 && multiproc_filter_bit && $rose(rx_done_flag_r)
      |-> rx_ninth_bit_r;
  endproperty
  a_ninth: assert property (p_ninth)
    else $error("frame kept with bad stop bit");
endmodule

bind serial_port serial_port_props u_props (.ref_clk, .rst,
  .rx_baud_from_timer2_sel, .tx_baud_from_timer2_sel, .port2_rx_baud_sel,
  .port2_tx_baud_sel, .timer2_run, .timer2_ext_enable, .timer2_ext_pin,
  .serial_mode, .multiproc_filter_bit, .tx_flag_clr, .rx_flag_clr,
  .txd_out_r, .serial_buffer_r, .rx_ninth_bit_r, .tx_done_flag_r,
  .rx_done_flag_r, .timer2_high_byte, .timer2_low_byte,
  .timer2_overflow_flag, .timer2_ext_flag);

`default_nettype wire

// ---- verif/serial_peer.sv ----
// remote peer: ten-bit frame sender and mode 0 shift partner
// assumes the line idles high through a pull-up, txd is shift clock
`timescale 1ns/10ps
`default_nettype none

module serial_peer (
  input  wire logic ref_clk,
  input  wire logic txd,
  output var  logic line
);
  logic [7:0] shift_r = 8'h00;
  int         left    = 0;
  initial line = 1'b1;
  // next bit lsb first on each falling shift clock
  always @(negedge txd) begin
    if (left > 0) begin
      line <= shift_r[0];
      shift_r <= shift_r >> 1;
      left <= left - 1;
    end
  end
  // back to the pull-up after the last bit
  always @(posedge txd) begin
    if (left == 0) begin
      line <= 1'b1;
    end
  end
  task automatic load_shift(input logic [7:0] d);
    shift_r = d;
    left = 8;
  endtask
  // start, data lsb first, stop
  task automatic send_frame(input logic [7:0] d, input logic stop);
    logic [9:0] frame;
    frame = {stop, d, 1'b0};
    for (int i = 0; i < 10; i++) begin
      line <= frame[i];
      repeat (32) @(posedge ref_clk);
    end
    line <= 1'b1;
  endtask
  task automatic pulse_low(input int n);
    line <= 1'b0;
    repeat (n) @(posedge ref_clk);
    line <= 1'b1;
  endtask
endmodule

`default_nettype wire

// ---- verif/serial_port_bench.sv ----
// self-checking bench for serial_port in modes 0 and 1
// assumes serial_peer on the receive pin, timer 2 as baud source
`timescale 1ns/10ps
`default_nettype none

module serial_port_bench;
  logic       ref_clk, rst, port_two_sel, rx_baud_from_timer2_sel;
  logic       tx_baud_from_timer2_sel, port2_rx_baud_sel, port2_tx_baud_sel;
  logic       timer1_tick16, timer2_run, timer2_counter_select;
  logic       timer2_ext_enable, timer2_ext_pin, timer2_count_pin;
  logic       timer2_wr_high, timer2_wr_low, timer2_wr_rld_high;
  logic       timer2_wr_rld_low, timer2_ovf_clr, timer2_ext_clr;
  logic [7:0] timer2_wr_data, buf_wr_data, serial_buffer_r, timer2_reload_low;
  logic [7:0] timer2_high_byte, timer2_low_byte, timer2_reload_high;
  logic [1:0] serial_mode;
  logic       rx_enable, multiproc_filter_bit, buf_wr, tx_flag_clr;
  logic       rx_flag_clr, rxd_in, rxd_out_r, rxd_oe_r, txd_out_r;
  logic       rx_ninth_bit_r, tx_done_flag_r, rx_done_flag_r;
  logic       timer2_overflow_flag, timer2_ext_flag;
  int         num_errors = 0, check_count = 0, cycles = 0;

  serial_port u_dut (.*);
  serial_peer u_peer (.ref_clk, .txd(txd_out_r), .line(rxd_in));

  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  // cut a hang short
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      tally_and_finish;
    end
  end

  task automatic tally_and_finish;
    if (num_errors == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] exp, got);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic clk(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic t2_write(input logic [3:0] s, input logic [7:0] d);
    clk(1);
    {timer2_wr_high, timer2_wr_low, timer2_wr_rld_high,
     timer2_wr_rld_low} <= s;
    timer2_wr_data <= d;
    clk(1);
    {timer2_wr_high, timer2_wr_low, timer2_wr_rld_high,
     timer2_wr_rld_low} <= 4'h0;
  endtask
  task automatic wait_txd(input logic lvl);
    int n = 0;
    while (txd_out_r !== lvl && n < 600) begin
      clk(1);
      n++;
    end
    chk("txd level", 16'(lvl), 16'(txd_out_r));
  endtask
  task automatic send_byte(input logic [7:0] d);
    clk(1);
    buf_wr <= 1'b1;
    buf_wr_data <= d;
    clk(1);
    buf_wr <= 1'b0;
  endtask
  task automatic clear_flags;
    clk(1);
    tx_flag_clr <= 1'b1;
    rx_flag_clr <= 1'b1;
    clk(1);
    tx_flag_clr <= 1'b0;
    rx_flag_clr <= 1'b0;
    clk(2);
  endtask

  // timer stopped: ext fall flags only; running: reload, no flag
  task automatic t_timer2;
    timer2_run <= 1'b0;
    t2_write(4'hc, 8'h12);
    t2_write(4'h3, 8'hff);
    timer2_ext_enable <= 1'b1;
    timer2_ext_pin <= 1'b0;
    clk(10);
    chk("ext flag", 16'h1, 16'(timer2_ext_flag));
    chk("timer bytes", 16'h1212, {timer2_high_byte, timer2_low_byte});
    timer2_ext_pin <= 1'b1;
    timer2_ext_enable <= 1'b0;
    timer2_ext_clr <= 1'b1;
    clk(1);
    timer2_ext_clr <= 1'b0;
    t2_write(4'hc, 8'hff);
    timer2_run <= 1'b1;
    clk(200);
    chk("ext flag clr", 16'h0, 16'(timer2_ext_flag));
    chk("ovf flag", 16'h0, 16'(timer2_overflow_flag));
    chk("timer high", 16'hff, 16'(timer2_high_byte));
    chk("rld", 16'hffff, {timer2_reload_high, timer2_reload_low});
  endtask
  // mode 0 transmit: 8 clocked bits lsb first on rxd, then flag
  task automatic t_mode0_tx;
    logic [7:0] got;
    send_byte(8'h96);
    for (int i = 0; i < 8; i++) begin
      wait_txd(1'b0);
      chk("m0 oe", 16'h1, 16'(rxd_oe_r));
      got[i] = rxd_out_r;
      wait_txd(1'b1);
    end
    clk(4);
    chk("m0 tx data", 16'h96, 16'(got));
    chk("m0 tx flag", 16'h1, 16'(tx_done_flag_r));
  endtask
  // mode 0 receive from the shift partner
  task automatic t_mode0_rx;
    int n = 0;
    u_peer.load_shift(8'h5b);
    rx_enable <= 1'b1;
    while (rx_done_flag_r !== 1'b1 && n < 200) begin
      clk(1);
      n++;
    end
    rx_enable <= 1'b0;
    chk("m0 rx flag", 16'h1, 16'(rx_done_flag_r));
    chk("m0 rx buf", 16'h5b, 16'(serial_buffer_r));
  endtask
  // mode 1 transmit sampled mid-bit at 32 clocks a bit
  task automatic t_mode1_tx(input logic [7:0] d);
    send_byte(d);
    wait_txd(1'b0);
    clk(16);
    chk("m1 start", 16'h0, 16'(txd_out_r));
    for (int i = 0; i < 8; i++) begin
      clk(32);
      chk("m1 data", 16'(d[i]), 16'(txd_out_r));
    end
    clk(32);
    chk("m1 stop", 16'h1, 16'(txd_out_r));
    chk("m1 tx flag", 16'h1, 16'(tx_done_flag_r));
  endtask
  task automatic t_mode1_rx(input logic [7:0] d, input logic stop,
                            input logic [8:0] exp_buf, input logic exp_flag);
    u_peer.send_frame(d, stop);
    clk(40);
    chk("m1 rx flag", 16'(exp_flag), 16'(rx_done_flag_r));
    chk("m1 rx buf", 16'(exp_buf), {7'h0, rx_ninth_bit_r, serial_buffer_r});
  endtask
  // short low pulse is not a start bit
  task automatic t_false_start;
    u_peer.pulse_low(6);
    clk(400);
    chk("false start", 16'h0, 16'(rx_done_flag_r));
  endtask

  initial begin
    rst = 1'b1;
    {port_two_sel, rx_baud_from_timer2_sel, port2_rx_baud_sel,
     port2_tx_baud_sel, timer1_tick16, timer2_run, timer2_counter_select,
     timer2_ext_enable, timer2_wr_high, timer2_wr_low, timer2_wr_rld_high,
     timer2_wr_rld_low, timer2_ovf_clr, timer2_ext_clr, rx_enable,
     multiproc_filter_bit, buf_wr, tx_flag_clr, rx_flag_clr} = '0;
    {timer2_wr_data, buf_wr_data, serial_mode} = '0;
    tx_baud_from_timer2_sel = 1'b1;
    timer2_ext_pin = 1'b1;
    timer2_count_pin = 1'b1;
    clk(3);
    rst <= 1'b0;
    clk(1);
    chk("reset outs", 16'h8, {txd_out_r, rxd_oe_r, tx_done_flag_r, rx_done_flag_r});
    t_timer2;
    t_mode0_tx;
    t_mode0_rx;
    clear_flags;
    serial_mode <= 2'h1;
    t_mode1_tx(8'hc5);
    port_two_sel <= 1'b1;
    port2_rx_baud_sel <= 1'b1;
    rx_enable <= 1'b1;
    t_mode1_rx(8'ha5, 1'b1, 9'h1a5, 1'b1);
    t_mode1_rx(8'h3c, 1'b1, 9'h1a5, 1'b1);
    clear_flags;
    multiproc_filter_bit <= 1'b1;
    t_mode1_rx(8'h77, 1'b0, 9'h1a5, 1'b0);
    t_false_start;
    t_mode1_rx(8'h5a, 1'b1, 9'h15a, 1'b1);
    tally_and_finish;
  end
endmodule

`default_nettype wire
